/* shared/gss_pkg.sv */
// constants and types for the servo gain set selector
// ------------------------------------------------------------
// Contract
// (R1) both switched-set conditions true: the second switched set wins
// (R2) primary source: 0 off, 1 signal/command, 2 freq, 3 droop, 4 speed, 5 direction
// (R3) level sources: polarity 0 means at/above threshold, 1 at/below
// (R4) signal source: polarity 0 active while signal on, 1 while off
// (R5) direction source: polarity 0 on negative command, 1 on positive
// (R6) time-constant disable: 0 always smooth, 1 skip entering, 2 skip returning
// (R7) second-set source: 0 off, 1 own signal/command, 2 primary source vs threshold 2
// (R8) second-set same-source with signal primary: second set follows the signal
// (R9) stop enable gates second set while stopped; direction source, position modes only
// (R10) second threshold zero: never enter second set by comparison
// (R11) software programs second threshold above the first
// (R12) sources 2,3,4 compare frequency, droop or speed against first threshold
// (R13) every transition passes a first-order lag, own time constant per set; code skips the lag under R6 bypass or a zero time constant
// (R14) software raises first time constant if switching is rough
// (R15) switching only in manual gain adjustment mode, code 3
// (R16) original set held after reset until a condition first holds
// ------------------------------------------------------------
`default_nettype none

package gss_pkg;

  localparam logic [3:0] SRC_OFF        = 4'h0;
  localparam logic [3:0] SRC_SIGNAL     = 4'h1;
  localparam logic [3:0] SRC_CMD_FREQ   = 4'h2;
  localparam logic [3:0] SRC_DROOP      = 4'h3;
  localparam logic [3:0] SRC_SPEED      = 4'h4;
  localparam logic [3:0] SRC_DIRECTION  = 4'h5;

  localparam logic       POL_HIGH_ON    = 1'h0;
  localparam logic       POL_LOW_ON     = 1'h1;

  localparam logic [3:0] TCD_ALWAYS     = 4'h0;
  localparam logic [3:0] TCD_NO_ENTRY   = 4'h1;
  localparam logic [3:0] TCD_NO_RETURN  = 4'h2;

  localparam logic [3:0] SET2_OFF       = 4'h0;
  localparam logic [3:0] SET2_SIGNAL    = 4'h1;
  localparam logic [3:0] SET2_SAME      = 4'h2;

  localparam logic [3:0] MODE_MANUAL    = 4'h3;

  localparam int         WGT_W          = 16;
  localparam int         TC_W           = 16;
  localparam logic [WGT_W-1:0] WGT_ZERO = 16'h0000;
  localparam logic [WGT_W-1:0] WGT_FULL = 16'hFFFF;
  localparam logic [WGT_W-1:0] RST_WEIGHT = 16'h0000;

  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         MS_IN_NS       = 1000000;
  localparam int         TICK_CYCLES    = MS_IN_NS / CLK_PERIOD_NS;
  localparam int         TICK_CNT_W     = 20;
  localparam logic [TICK_CNT_W-1:0] RST_TICK_CNT = 20'h00000;

  typedef enum logic [1:0] {
    GSS_SET_ORIG,
    GSS_SET_1,
    GSS_SET_2
  } gss_set_t;

  localparam gss_set_t   RST_SET        = GSS_SET_ORIG;

endpackage

`default_nettype wire

/* shared/gss_lag_if.sv */
// link between the selector and one first-order lag filter
`default_nettype none

interface gss_lag_if;
  import gss_pkg::*;

  logic                   tick;
  logic                   target_full;
  logic                   bypass;
  logic [TC_W-1:0]        tc;
  logic [WGT_W-1:0]       weight;

  modport ctrl (output tick, output target_full, output bypass, output tc, input weight);
  modport filt (input tick, input target_full, input bypass, input tc, output weight);
endinterface

`default_nettype wire

/* design/gss_lag_filter.sv */
// first-order lag that moves one blend weight toward empty or full
`default_nettype none

module gss_lag_filter
  import gss_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   sys_rst,
  gss_lag_if.filt     lag
);

  logic [WGT_W-1:0] weight_reg;
  logic [WGT_W-1:0] weight_next;

  // ------------------------------------------------------------
  // euler step per millisecond: w += (goal - w) / tc
  // ------------------------------------------------------------
  always_comb begin
    logic [WGT_W-1:0]        goal;
    logic signed [WGT_W+1:0] diff;
    logic signed [WGT_W+1:0] divisor;
    logic signed [WGT_W+1:0] step;
    logic signed [WGT_W+1:0] sum;
    goal    = lag.target_full ? WGT_FULL : WGT_ZERO;
    diff    = $signed({2'b00, goal}) - $signed({2'b00, weight_reg});
    // zero guard only; a zero constant bypasses below
    divisor = (lag.tc == '0) ? 18'sh00001 : $signed({2'b00, lag.tc});
    step    = diff / divisor;
    // never stall short of the goal on truncation
    if (step == '0 && diff > 0) begin
      step = 18'sh00001;
    end else if (step == '0 && diff < 0) begin
      step = -18'sh00001;
    end
    sum         = $signed({2'b00, weight_reg}) + step;
    weight_next = weight_reg;
    if (lag.bypass || lag.tc == '0) begin
      weight_next = goal; // R6
    end else if (lag.tick) begin
      weight_next = sum[WGT_W-1:0]; // R13
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      weight_reg <= RST_WEIGHT;
    end else begin
      weight_reg <= weight_next;
    end
  end

  assign lag.weight = weight_reg;

endmodule

`default_nettype wire

/* design/gss_selector.sv */
// servo gain set selector: decides the active set and smooths the change
`default_nettype none

module gss_selector
  import gss_pkg::*;
#(
  parameter int MEAS_W          = 32,
  parameter int TICK_CYCLES_P   = TICK_CYCLES
)(
  input  wire logic                clock,
  input  wire logic                sys_rst,
  // configuration
  input  wire logic [3:0]          gain_adjust_mode_select,
  input  wire logic [3:0]          primary_source_select,
  input  wire logic                primary_polarity_select,
  input  wire logic [3:0]          time_constant_disable_select,
  input  wire logic [3:0]          set2_source_select,
  input  wire logic                set2_stop_enable,
  input  wire logic [MEAS_W-1:0]   set1_threshold_param,
  input  wire logic [MEAS_W-1:0]   set2_threshold_param,
  input  wire logic [TC_W-1:0]     set1_time_constant_param,
  input  wire logic [TC_W-1:0]     set2_time_constant_param,
  // switching requests
  input  wire logic                gain_set1_request_input,
  input  wire logic                gain_set1_request_cmd,
  input  wire logic                gain_set2_request_input,
  input  wire logic                gain_set2_request_cmd,
  // loop state, magnitudes already absolute
  input  wire logic [MEAS_W-1:0]   cmd_frequency,
  input  wire logic [MEAS_W-1:0]   droop_pulses,
  input  wire logic [MEAS_W-1:0]   motor_speed,
  input  wire logic                cmd_dir_negative,
  input  wire logic                cmd_dir_positive,
  input  wire logic                motor_stopped,
  input  wire logic                position_mode,
  // results
  output logic [1:0]               active_set,
  output logic                     set1_enabled_status,
  output logic                     set2_enabled_status,
  output logic                     switching_allowed,
  output logic [WGT_W-1:0]         set1_weight,
  output logic [WGT_W-1:0]         set2_weight
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic level_hit(
    input logic [MEAS_W-1:0] meas,
    input logic [MEAS_W-1:0] thr,
    input logic              pol
  );
    logic hit;
    hit = 1'b0;
    if (pol == POL_HIGH_ON) begin
      hit = (meas >= thr);
    end else begin
      hit = (meas <= thr);
    end
    return hit;
  endfunction

  function automatic logic apply_pol(
    input logic level,
    input logic pol
  );
    return (pol == POL_HIGH_ON) ? level : ~level;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] req1_sync_reg;
  logic [1:0] req1_sync_next;
  logic [1:0] req2_sync_reg;
  logic [1:0] req2_sync_next;

  always_comb begin
    req1_sync_next = {req1_sync_reg[0], gain_set1_request_input};
    req2_sync_next = {req2_sync_reg[0], gain_set2_request_input};
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      req1_sync_reg <= 2'h0;
      req2_sync_reg <= 2'h0;
    end else begin
      req1_sync_reg <= req1_sync_next;
      req2_sync_reg <= req2_sync_next;
    end
  end

  logic sig1;
  logic sig2;
  assign sig1 = req1_sync_reg[1] | gain_set1_request_cmd;
  assign sig2 = req2_sync_reg[1] | gain_set2_request_cmd;

  // ------------------------------------------------------------
  // condition evaluation
  // ------------------------------------------------------------
  logic cond1_reg;
  logic cond1_next;
  logic cond2_reg;
  logic cond2_next;
  logic manual_reg;
  logic manual_next;

  always_comb begin
    logic [MEAS_W-1:0] meas;
    logic              dir_hit;
    logic              stop_block;
    meas       = '0;
    dir_hit    = 1'b0;
    stop_block = 1'b0;
    // R12
    case (primary_source_select)
      SRC_CMD_FREQ: meas = cmd_frequency;
      SRC_DROOP:    meas = droop_pulses;
      SRC_SPEED:    meas = motor_speed;
      default:      meas = '0;
    endcase
    // R5
    dir_hit = (primary_polarity_select == POL_HIGH_ON) ? cmd_dir_negative
                                                       : cmd_dir_positive;
    // R9
    stop_block = position_mode && motor_stopped && !set2_stop_enable;

    // R2
    case (primary_source_select)
      SRC_SIGNAL:    cond1_next = apply_pol(sig1, primary_polarity_select); // R4
      SRC_CMD_FREQ,
      SRC_DROOP,
      SRC_SPEED:     cond1_next = level_hit(meas, set1_threshold_param,
                                            primary_polarity_select); // R3
      SRC_DIRECTION: cond1_next = dir_hit;
      default:       cond1_next = 1'b0;
    endcase

    // R7
    case (set2_source_select)
      SET2_SIGNAL: cond2_next = sig2;
      SET2_SAME: begin
        case (primary_source_select)
          SRC_SIGNAL:    cond2_next = apply_pol(sig1, primary_polarity_select); // R8
          SRC_CMD_FREQ,
          SRC_DROOP,
          SRC_SPEED:     cond2_next = (set2_threshold_param != '0) && // R10
                                      level_hit(meas, set2_threshold_param,
                                                primary_polarity_select);
          SRC_DIRECTION: cond2_next = dir_hit && !stop_block; // R9
          default:       cond2_next = 1'b0;
        endcase
      end
      default:     cond2_next = 1'b0;
    endcase

    manual_next = (gain_adjust_mode_select == MODE_MANUAL); // R15
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cond1_reg  <= 1'b0;
      cond2_reg  <= 1'b0;
      manual_reg <= 1'b0;
    end else begin
      cond1_reg  <= cond1_next;
      cond2_reg  <= cond2_next;
      manual_reg <= manual_next;
    end
  end

  // ------------------------------------------------------------
  // active set decision
  // ------------------------------------------------------------
  gss_set_t set_reg;
  gss_set_t set_next;
  logic     stat1_reg;
  logic     stat1_next;
  logic     stat2_reg;
  logic     stat2_next;

  always_comb begin
    set_next = GSS_SET_ORIG;
    if (!manual_reg) begin
      set_next = GSS_SET_ORIG; // R15
    end else if (cond2_reg) begin
      set_next = GSS_SET_2; // R1
    end else if (cond1_reg) begin
      set_next = GSS_SET_1;
    end
    stat1_next = (set_next == GSS_SET_1);
    stat2_next = (set_next == GSS_SET_2);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      set_reg   <= RST_SET; // R16
      stat1_reg <= 1'b0;
      stat2_reg <= 1'b0;
    end else begin
      set_reg   <= set_next;
      stat1_reg <= stat1_next;
      stat2_reg <= stat2_next;
    end
  end

  // ------------------------------------------------------------
  // millisecond tick for the lag filters
  // ------------------------------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt_reg;
  logic [TICK_CNT_W-1:0] tick_cnt_next;
  logic                  tick_reg;
  logic                  tick_next;

  always_comb begin
    tick_next = 1'b0;
    if (tick_cnt_reg >= TICK_CNT_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt_next = RST_TICK_CNT;
      tick_next     = 1'b1;
    end else begin
      tick_cnt_next = tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= RST_TICK_CNT;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ------------------------------------------------------------
  // smoothing, one lag per switched set
  // ------------------------------------------------------------
  gss_lag_if lag1 ();
  gss_lag_if lag2 ();

  logic entering;
  logic returning;

  // entering means a switched set is the goal; returning means the original is
  assign entering  = (set_reg != GSS_SET_ORIG);
  assign returning = (set_reg == GSS_SET_ORIG);

  assign lag1.tick        = tick_reg;
  assign lag1.target_full = (set_reg == GSS_SET_1);
  assign lag1.tc          = set1_time_constant_param; // R13
  assign lag2.tick        = tick_reg;
  assign lag2.target_full = (set_reg == GSS_SET_2);
  assign lag2.tc          = set2_time_constant_param; // R13

  // R6
  assign lag1.bypass = (time_constant_disable_select == TCD_NO_ENTRY  && entering) ||
                       (time_constant_disable_select == TCD_NO_RETURN && returning);
  assign lag2.bypass = (time_constant_disable_select == TCD_NO_ENTRY  && entering) ||
                       (time_constant_disable_select == TCD_NO_RETURN && returning);

  gss_lag_filter u_lag1 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .lag     (lag1.filt)
  );

  gss_lag_filter u_lag2 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .lag     (lag2.filt)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign active_set          = set_reg;
  assign set1_enabled_status = stat1_reg;
  assign set2_enabled_status = stat2_reg;
  assign switching_allowed   = manual_reg;
  assign set1_weight         = lag1.weight;
  assign set2_weight         = lag2.weight;

endmodule

`default_nettype wire

/* dv/gss_selector_sva.sv */
// assertion checker for the gain set selector ports
`default_nettype none
module gss_selector_sva
  import gss_pkg::*;
#(
  parameter int MEAS_W = 32
)(
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic [3:0]        gain_adjust_mode_select,
  input wire logic [3:0]        primary_source_select,
  input wire logic              primary_polarity_select,
  input wire logic [3:0]        time_constant_disable_select,
  input wire logic [3:0]        set2_source_select,
  input wire logic [MEAS_W-1:0] set1_threshold_param,
  input wire logic [MEAS_W-1:0] set2_threshold_param,
  input wire logic [TC_W-1:0]   set1_time_constant_param,
  input wire logic [MEAS_W-1:0] motor_speed,
  input wire logic              cmd_dir_negative,
  input wire logic              cmd_dir_positive,
  input wire logic [1:0]        active_set,
  input wire logic              set1_enabled_status,
  input wire logic              set2_enabled_status,
  input wire logic [WGT_W-1:0]  set1_weight
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic man = gain_adjust_mode_select == MODE_MANUAL;
  wire logic pol = primary_polarity_select;
  wire logic spd = man && primary_source_select == SRC_SPEED;
  wire logic lv1 = pol ? motor_speed <= set1_threshold_param : motor_speed >= set1_threshold_param;
  wire logic lv2 = pol ? motor_speed <= set2_threshold_param : motor_speed >= set2_threshold_param;
  wire logic tcd0 = time_constant_disable_select == TCD_ALWAYS;

  mode_gate_a: assert property (!man |-> ##2 active_set == 2'h0)
    else $error("switched set outside manual mode");
  status_onehot_a: assert property (set1_enabled_status == (active_set == 2'h1) &&
    set2_enabled_status == (active_set == 2'h2)) else $error("status not one-hot of set");
  level_hit_a: assert property (spd && set2_source_select == SET2_OFF && lv1
    |-> ##2 active_set == 2'h1) else $error("level hit did not select set 1");
  level_miss_a: assert property (spd && set2_source_select == SET2_OFF && !lv1
    |-> ##2 active_set == 2'h0) else $error("level miss left a switched set");
  dir_hit_a: assert property (man && primary_source_select == SRC_DIRECTION &&
    set2_source_select == SET2_OFF && (pol ? cmd_dir_positive : cmd_dir_negative)
    |-> ##2 active_set == 2'h1) else $error("direction did not select set 1");
  set2_wins_a: assert property (spd && set2_source_select == SET2_SAME && lv1 && lv2 &&
    set2_threshold_param != '0 |-> ##2 active_set == 2'h2) else $error("set 2 lost priority");
  thr2_zero_a: assert property (set2_source_select == SET2_SAME &&
    set2_threshold_param == '0 && primary_source_select inside {[4'h2:4'h4]}
    |-> ##2 active_set != 2'h2) else $error("set 2 entered with zero threshold");
  entry_jump_a: assert property (time_constant_disable_select == TCD_NO_ENTRY &&
    $rose(set1_enabled_status) |=> set1_weight == WGT_FULL) else $error("entry not bypassed");
  return_jump_a: assert property (time_constant_disable_select == TCD_NO_RETURN &&
    $fell(set1_enabled_status) && active_set == 2'h0 |=> set1_weight == WGT_ZERO)
    else $error("return not bypassed");
  smooth_a: assert property (tcd0 && set1_time_constant_param > 16'h0001 &&
    $rose(set1_enabled_status) && set1_weight == WGT_ZERO |=> set1_weight != WGT_FULL)
    else $error("smoothed change jumped");
  cover property (active_set == 2'h2);
  cover property ($rose(set1_enabled_status) && !tcd0);
  cover property (set1_weight == WGT_FULL && tcd0);
endmodule
`default_nettype wire

/* dv/gss_loop_model.sv */
// servo loop model that blends three gain values by the selector weights
`default_nettype none
module gss_loop_model (
  input wire logic         clock,
  input wire logic [15:0]  set1_weight,
  input wire logic [15:0]  set2_weight,
  input wire logic [15:0]  gain_orig,
  input wire logic [15:0]  gain_set1,
  input wire logic [15:0]  gain_set2,
  output var logic [15:0]  gain_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // weights may overlap during a 1 to 2 change, so the original share clamps at zero
  logic [16:0] wsum;
  logic [15:0] w0;
  assign wsum = {1'b0, set1_weight} + {1'b0, set2_weight};
  assign w0 = wsum > 17'h0FFFF ? 16'h0000 : 16'hFFFF - wsum[15:0];
  always @(posedge clock) begin
    gain_out <= 16'((34'(w0) * gain_orig + 34'(set1_weight) * gain_set1
                     + 34'(set2_weight) * gain_set2) / 34'h0FFFF);
  end
endmodule
`default_nettype wire

/* dv/gss_selector_bench.sv */
// self-checking bench for the gain set selector
`default_nettype none
module gss_selector_bench
  import gss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, sys_rst, primary_polarity_select, set2_stop_enable, motor_stopped;
  logic        gain_set1_request_input, gain_set1_request_cmd, position_mode;
  logic        gain_set2_request_input, gain_set2_request_cmd;
  logic        cmd_dir_negative, cmd_dir_positive, set1_enabled_status, set2_enabled_status;
  logic [3:0]  gain_adjust_mode_select, primary_source_select;
  logic [3:0]  time_constant_disable_select, set2_source_select;
  logic [31:0] set1_threshold_param, set2_threshold_param, cmd_frequency, droop_pulses;
  logic [31:0] motor_speed;
  logic [15:0] set1_time_constant_param, set2_time_constant_param;
  logic [15:0] set1_weight, set2_weight, gain_out;
  logic [1:0]  active_set;
  logic        switching_allowed;
  int          n_mismatch, samples_checked, cycles;

  gss_selector #(.TICK_CYCLES_P(10)) u_dut (.clock, .sys_rst, .gain_adjust_mode_select,
    .primary_source_select, .primary_polarity_select, .time_constant_disable_select,
    .set2_source_select, .set2_stop_enable, .set1_threshold_param, .set2_threshold_param,
    .set1_time_constant_param, .set2_time_constant_param, .gain_set1_request_input,
    .gain_set1_request_cmd, .gain_set2_request_input, .gain_set2_request_cmd, .cmd_frequency,
    .droop_pulses, .motor_speed, .cmd_dir_negative, .cmd_dir_positive, .motor_stopped,
    .position_mode, .active_set, .set1_enabled_status, .set2_enabled_status,
    .switching_allowed, .set1_weight, .set2_weight);
  gss_loop_model u_loop (.clock, .set1_weight, .set2_weight, .gain_orig(16'h1000),
    .gain_set1(16'h2000), .gain_set2(16'h3000), .gain_out);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  function automatic logic [1:0] exp_set();
    logic c1, c2, ps;
    logic [31:0] m;
    ps = primary_polarity_select;
    m = primary_source_select == SRC_CMD_FREQ ? cmd_frequency :
        primary_source_select == SRC_DROOP ? droop_pulses : motor_speed;
    c1 = 1'b0;
    c2 = 1'b0;
    case (primary_source_select)
      SRC_SIGNAL: c1 = (gain_set1_request_input | gain_set1_request_cmd) ^ ps;
      SRC_CMD_FREQ, SRC_DROOP, SRC_SPEED: c1 = ps ? m <= set1_threshold_param
                                                  : m >= set1_threshold_param;
      SRC_DIRECTION: c1 = ps ? cmd_dir_positive : cmd_dir_negative;
      default: c1 = 1'b0;
    endcase
    if (set2_source_select == SET2_SIGNAL) c2 = gain_set2_request_input | gain_set2_request_cmd;
    if (set2_source_select == SET2_SAME) begin
      case (primary_source_select)
        SRC_SIGNAL: c2 = c1;
        SRC_CMD_FREQ, SRC_DROOP, SRC_SPEED: c2 = set2_threshold_param != 32'h0 &&
          (ps ? m <= set2_threshold_param : m >= set2_threshold_param);
        SRC_DIRECTION: c2 = c1 && !(position_mode && motor_stopped && !set2_stop_enable);
        default: c2 = 1'b0;
      endcase
    end
    if (gain_adjust_mode_select != MODE_MANUAL) return 2'h0;
    return c2 ? 2'h2 : (c1 ? 2'h1 : 2'h0);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  // waits out the pin synchroniser plus the two-stage decision
  task automatic check_set();
    logic [1:0] e;
    cyc(6);
    e = exp_set();
    chk({12'h0, set2_enabled_status, set1_enabled_status, active_set},
        {12'h0, e == 2'h2, e == 2'h1, e});
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {primary_polarity_select, set2_stop_enable, motor_stopped, position_mode} = 4'h0;
    {gain_set1_request_input, gain_set1_request_cmd, gain_set2_request_input} = 3'h0;
    {gain_set2_request_cmd, cmd_dir_negative, cmd_dir_positive} = 3'h0;
    {time_constant_disable_select, set2_source_select} = 8'h00;
    gain_adjust_mode_select = MODE_MANUAL;
    primary_source_select = SRC_SPEED;
    set1_threshold_param = 32'h00000064;
    set2_threshold_param = 32'h000000C8;
    {cmd_frequency, droop_pulses} = 64'h0;
    motor_speed = 32'h00000032;
    set1_time_constant_param = 16'h0004;
    set2_time_constant_param = 16'h0000;
    cyc(12);
    sys_rst = 1'b0;
    check_set();
    chk(set1_weight | set2_weight, WGT_ZERO);
    for (int s = 0; s < 6; s++) for (int p = 0; p < 2; p++) for (int v = 0; v < 3; v++) begin
      primary_source_select = 4'(s);
      primary_polarity_select = p[0];
      motor_speed = 32'(98 + 2 * v);
      cmd_frequency = 32'(99 + v);
      droop_pulses = 32'(101 - v);
      gain_set1_request_cmd = v == 1;
      gain_set1_request_input = v == 2;
      cmd_dir_negative = v == 0;
      cmd_dir_positive = v == 2;
      check_set();
    end
    {gain_set1_request_cmd, gain_set1_request_input, primary_polarity_select} = 3'h0;
    primary_source_select = SRC_SPEED;
    set2_source_select = SET2_SIGNAL;
    for (int v = 0; v < 6; v++) begin
      motor_speed = v[0] ? 32'h00000096 : 32'h00000032;
      gain_set2_request_cmd = v[1] & ~v[2];
      gain_set2_request_input = v[2];
      check_set();
    end
    {gain_set2_request_cmd, gain_set2_request_input} = 2'h0;
    set2_source_select = SET2_SAME;
    for (int t = 0; t < 2; t++) for (int p = 0; p < 2; p++) for (int v = 0; v < 4; v++) begin
      set2_threshold_param = t ? 32'h0 : 32'h000000C8;
      primary_polarity_select = p[0];
      motor_speed = 32'(50 + 50 * v);
      check_set();
    end
    primary_polarity_select = 1'b0;
    primary_source_select = SRC_SIGNAL;
    for (int v = 0; v < 2; v++) begin
      gain_set1_request_cmd = v[0];
      check_set();
    end
    primary_source_select = SRC_DIRECTION;
    cmd_dir_negative = 1'b1;
    for (int k = 0; k < 8; k++) begin
      {position_mode, motor_stopped, set2_stop_enable} = 3'(k);
      check_set();
    end
    primary_source_select = SRC_SPEED;
    set2_source_select = SET2_OFF;
    motor_speed = 32'h00000096;
    for (int m = 0; m < 8; m++) begin
      gain_adjust_mode_select = 4'(m);
      check_set();
      chk({15'h0, switching_allowed}, {15'h0, 4'(m) == MODE_MANUAL});
    end
    // the weight scenarios below need switching allowed again
    gain_adjust_mode_select = MODE_MANUAL;
    time_constant_disable_select = TCD_NO_ENTRY;
    motor_speed = 32'h00000032;
    cyc(2000);
    motor_speed = 32'h00000096;
    cyc(4);
    chk(set1_weight, WGT_FULL);
    time_constant_disable_select = TCD_NO_RETURN;
    motor_speed = 32'h00000032;
    cyc(4);
    chk(set1_weight, WGT_ZERO);
    time_constant_disable_select = TCD_ALWAYS;
    motor_speed = 32'h00000096;
    cyc(4);
    // at most one tick has passed: one quarter step from empty at most
    chk({15'h0, set1_weight < 16'h4000}, 16'h0001);
    cyc(2000);
    chk(gain_out, 16'h2000);
    set2_source_select = SET2_SIGNAL;
    gain_set2_request_cmd = 1'b1;
    cyc(6);
    chk(set2_weight, WGT_FULL);
    cyc(2000);
    chk(gain_out, 16'h3000);
    tally_and_finish();
  end
endmodule

bind gss_selector gss_selector_sva #(.MEAS_W(MEAS_W)) u_sva (.clock, .sys_rst,
  .gain_adjust_mode_select, .primary_source_select, .primary_polarity_select,
  .time_constant_disable_select, .set2_source_select, .set1_threshold_param,
  .set2_threshold_param, .set1_time_constant_param, .motor_speed, .cmd_dir_negative,
  .cmd_dir_positive, .active_set, .set1_enabled_status, .set2_enabled_status, .set1_weight);
`default_nettype wire
